// File: rtl/flash_prot_pkg.sv
// Shared constants for the flash protection policy block.
// Assumes an APB slave wrapper on pclk and a nonvolatile option store outside.
package flash_prot_pkg;
    // Readout protection levels, 0.5 is LVL_HALF
    typedef enum logic [1:0] {LVL_0 = 2'b00, LVL_HALF = 2'b01, LVL_1 = 2'b10, LVL_2 = 2'b11} rdp_level_t;
    // Source of an access
    typedef enum logic [1:0] {SRC_USER = 2'b00, SRC_DEBUG = 2'b01, SRC_RAMBOOT = 2'b10, SRC_LOADER = 2'b11} src_t;
    // Target area of an access
    typedef enum logic [2:0] {AREA_MAIN = 3'b000, AREA_SYSMEM = 3'b001, AREA_OPT = 3'b010,
        AREA_OTP = 3'b011, AREA_BKP = 3'b100, AREA_SECOND_SRAM_BANK = 3'b101} area_t;
    // Operation kind
    typedef enum logic [1:0] {OP_READ = 2'b00, OP_WRITE = 2'b01, OP_ERASE = 2'b10} op_t;
    // Option load sequencer
    typedef enum logic [1:0] {OB_SYNC = 2'b00, OB_IDLE = 2'b01, OB_PROG = 2'b10} ob_state_t;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] OPT_STAGE_OFF = 8'h04;
    localparam logic [7:0] WRP_STAGE_OFF = 8'h08;
    localparam logic [7:0] KEY_STAGE_OFF = 8'h0c;
    localparam logic [7:0] PASSWORD_OFF = 8'h10;
    localparam logic [7:0] STATUS_OFF = 8'h14;
    localparam logic [7:0] OTP_USED_OFF = 8'h18;

    // Control fields
    localparam int CTRL_PREFETCH_BIT = 0;
    localparam int CTRL_OPT_START_BIT = 1;
    // Option word fields
    localparam int OPT_LVL_LSB = 0;
    localparam int OPT_SEC_BIT = 2;
    localparam int OPT_KEYCFG_BIT = 3;
    localparam int OPT_W = 4;
    // Write protect word: A start, A end, B start, B end, one page index each
    localparam int PAGE_W = 7;
    localparam int WRP_W = 4 * PAGE_W;
    localparam int WRP_A_START_LSB = 0;
    localparam int WRP_A_END_LSB = 7;
    localparam int WRP_B_START_LSB = 14;
    localparam int WRP_B_END_LSB = 21;
    // Status fields
    localparam int ST_LVL_LSB = 0;
    localparam int ST_SEC_BIT = 2;
    localparam int ST_KEYCFG_BIT = 3;
    localparam int ST_AUTH_BIT = 4;
    localparam int ST_BUSY_BIT = 5;
    localparam int ST_REFUSED_BIT = 6;
    localparam int ST_DBG_BIT = 7;
    localparam int ST_PREFETCH_BIT = 8;

    // Geometry
    localparam int PAGE_COUNT = 128;
    localparam int PAGE_KBYTES = 8;
    localparam int OTP_BYTES = 512;
    localparam int OTP_ROW_BYTES = 16;
    localparam int OTP_ROWS = OTP_BYTES / OTP_ROW_BYTES;
    localparam int ROW_W = 5;
    localparam int KEY_W = 32;
    // Cycles from option program or reset release to capture of synchronised options
    localparam logic [2:0] SYNC_WAIT = 3'h4;
endpackage : flash_prot_pkg

// File: rtl/access_policy.sv
// Combinational access decision for one flash, OTP, backup or SRAM access.
// Assumes the caller registers the result and has mapped debug and boot state into the source.
`timescale 1ns/1ps
module access_policy #(
    parameter int PAGE_W = flash_prot_pkg::PAGE_W
) (
    input wire flash_prot_pkg::rdp_level_t level,
    input wire logic sec_en,
    input wire flash_prot_pkg::src_t src,
    input wire flash_prot_pkg::area_t area,
    input wire flash_prot_pkg::op_t op,
    input wire logic secure,
    input wire logic [PAGE_W-1:0] page,
    input wire logic [4*PAGE_W-1:0] write_protect_area,
    input wire logic otp_row_used,
    output logic grant
);
    // Page inside an inclusive window; an empty window (end below start) protects nothing
    function automatic logic in_window(input logic [PAGE_W-1:0] p, input logic [PAGE_W-1:0] s,
        input logic [PAGE_W-1:0] e);
        in_window = (s <= e) && (p >= s) && (p <= e);
    endfunction : in_window

    logic restricted; // Debug, RAM boot or bootloader
    logic prot_hit; // Page lies in a write protected area
    logic ns_debug; // Non-secure debug access

    assign restricted = (src != flash_prot_pkg::SRC_USER);
    assign ns_debug = sec_en && (src == flash_prot_pkg::SRC_DEBUG) && !secure;
    assign prot_hit = in_window(page, write_protect_area[flash_prot_pkg::WRP_A_START_LSB +: PAGE_W],
        write_protect_area[flash_prot_pkg::WRP_A_END_LSB +: PAGE_W])
        || in_window(page, write_protect_area[flash_prot_pkg::WRP_B_START_LSB +: PAGE_W],
        write_protect_area[flash_prot_pkg::WRP_B_END_LSB +: PAGE_W]);

    // Decision per area and level
    always_comb
    begin
        grant = 1'b0;
        case (area)
            flash_prot_pkg::AREA_MAIN:
            begin
                if ((op != flash_prot_pkg::OP_READ) && prot_hit)
                    grant = 1'b0;
                else if (level == flash_prot_pkg::LVL_0)
                    grant = 1'b1;
                else if (level == flash_prot_pkg::LVL_HALF)
                    grant = !(restricted && secure);
                else if (level == flash_prot_pkg::LVL_1)
                    grant = !restricted || ns_debug;
                else
                    grant = !restricted;
            end
            flash_prot_pkg::AREA_SYSMEM:
                grant = (op == flash_prot_pkg::OP_READ) && !(level == flash_prot_pkg::LVL_2 && restricted);
            flash_prot_pkg::AREA_OPT:
            begin
                if (op == flash_prot_pkg::OP_ERASE)
                    grant = 1'b0;
                else if (level == flash_prot_pkg::LVL_2)
                    grant = (op == flash_prot_pkg::OP_READ) && !restricted;
                else
                    grant = 1'b1;
            end
            flash_prot_pkg::AREA_OTP:
            begin
                if (op == flash_prot_pkg::OP_ERASE)
                    grant = 1'b0;
                else if (level == flash_prot_pkg::LVL_2 && restricted)
                    grant = 1'b0;
                else
                    grant = (op == flash_prot_pkg::OP_READ) || !otp_row_used;
            end
            flash_prot_pkg::AREA_BKP, flash_prot_pkg::AREA_SECOND_SRAM_BANK:
            begin
                if (op == flash_prot_pkg::OP_ERASE)
                    grant = 1'b0;
                else if (level == flash_prot_pkg::LVL_0)
                    grant = 1'b1;
                else if (level == flash_prot_pkg::LVL_HALF)
                    grant = !(restricted && secure);
                else if (level == flash_prot_pkg::LVL_1)
                    grant = !restricted || ns_debug;
                else
                    grant = !restricted;
            end
            default:
                grant = 1'b0; // Unknown area refused
        endcase
    end
endmodule : access_policy

// File: rtl/flash_prot.sv
// Flash readout and write protection policy with APB control registers.
// Assumes option bytes live in an outside store that updates on nv_prog and is read via nv_* pins.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - Levels and write areas come from options
// - Level 0 lets every source read
// - Level 0.5 needs security; blocks secure debug
// - Level 0.5 allows non-secure access except protected writes
// - Level 1 refuses flash to debug/RAM/loader boots
// - Level 1 secure: non-secure debug, no RAM boot
// - Level 1 regression may need correct password
// - Level 2 disables debug, RAM boot, loader
// - Level 2 without key is permanent
// - Key plus debug password allows 2 to 1
// - Two write areas refuse program and erase
// - 128 pages of 8K, 512-byte OTP
// - Prefetch off until software enables it
// - User code access set at levels 1, 2
// - Level 1 restricted sources: limited areas only
// - Level 1 to 0 erases main flash
// - Level 1 downward clears backup registers
// - Each OTP row written only once
// - Options change only via option start bit
module flash_prot #(
    parameter int PAGE_W = flash_prot_pkg::PAGE_W,
    parameter int OTP_ROWS = flash_prot_pkg::OTP_ROWS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] nv_level,
    input wire logic nv_sec_en,
    input wire logic nv_key_cfg,
    input wire logic [4*PAGE_W-1:0] nv_wrp,
    input wire logic [flash_prot_pkg::KEY_W-1:0] nv_key,
    output logic nv_prog,
    output logic [flash_prot_pkg::OPT_W-1:0] nv_prog_opt,
    output logic [4*PAGE_W-1:0] nv_prog_wrp,
    output logic [flash_prot_pkg::KEY_W-1:0] nv_prog_key,
    input wire logic dbg_attached,
    input wire logic [1:0] boot_sel,
    input wire logic acc_valid,
    input wire logic [1:0] acc_src,
    input wire logic [2:0] acc_area,
    input wire logic [1:0] acc_op,
    input wire logic acc_secure,
    input wire logic [PAGE_W-1:0] acc_page,
    input wire logic [flash_prot_pkg::ROW_W-1:0] acc_row,
    output logic acc_done,
    output logic acc_grant,
    output logic dbg_enable,
    output logic dbg_secure_enable,
    output logic boot_ram_allow,
    output logic boot_loader_allow,
    output logic prefetch_en,
    output logic mass_erase,
    output logic backup_clear
);
    // Two-stage synchronisers for pins from the option store and the debug and boot pins
    localparam int SYNC_W = 2 + 1 + 1 + 4 * PAGE_W + flash_prot_pkg::KEY_W + 1 + 2;
    logic [SYNC_W-1:0] sync1_q; // First stage, read only by sync2_q
    logic [SYNC_W-1:0] sync2_q; // Second stage
    logic [1:0] s_level;
    logic s_sec_en;
    logic s_key_cfg;
    logic [4*PAGE_W-1:0] s_wrp;
    logic [flash_prot_pkg::KEY_W-1:0] s_key;
    logic s_dbg;
    logic [1:0] s_boot;

    // Synchroniser chain
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= {nv_level, nv_sec_en, nv_key_cfg, nv_wrp, nv_key, dbg_attached, boot_sel};
            sync2_q <= sync1_q;
        end
    end
    assign {s_level, s_sec_en, s_key_cfg, s_wrp, s_key, s_dbg, s_boot} = sync2_q;

    // Loaded option state
    flash_prot_pkg::rdp_level_t level_q; // Active readout level
    logic sec_en_q; // Security extension enable
    logic key_cfg_q; // Regression key configured
    logic [4*PAGE_W-1:0] wrp_q; // Write protect bounds
    logic [flash_prot_pkg::KEY_W-1:0] key_q; // Regression password
    logic [1:0] boot_q; // Boot choice caught at load
    flash_prot_pkg::ob_state_t ob_state_q;
    logic [2:0] wait_q; // Cycles left before capture
    // Software registers
    logic prefetch_q;
    logic [flash_prot_pkg::OPT_W-1:0] opt_stage_q;
    logic [4*PAGE_W-1:0] wrp_stage_q;
    logic [flash_prot_pkg::KEY_W-1:0] key_stage_q;
    logic auth_q; // Password accepted
    logic refused_q; // Last option start was refused
    logic [OTP_ROWS-1:0] otp_used_q; // Rows already written
    // Bus handshake
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic bus_wr; // Write takes effect this edge
    logic bus_rd_phase; // Access phase before answer
    logic start_req; // Option start written
    logic start_ok; // Option start accepted
    flash_prot_pkg::rdp_level_t new_level;
    logic new_sec;
    logic mapped;

    assign bus_wr = psel && penable && pready_q && pwrite;
    assign bus_rd_phase = psel && penable && !pready_q;
    assign start_req = bus_wr && (paddr == flash_prot_pkg::CTRL_OFF)
        && pwdata[flash_prot_pkg::CTRL_OPT_START_BIT];
    assign new_level = flash_prot_pkg::rdp_level_t'(opt_stage_q[flash_prot_pkg::OPT_LVL_LSB +: 2]);
    assign new_sec = opt_stage_q[flash_prot_pkg::OPT_SEC_BIT];

    // Regression and level selection check for a requested option program
    always_comb
    begin
        start_ok = (ob_state_q == flash_prot_pkg::OB_IDLE);
        if (new_level == flash_prot_pkg::LVL_HALF && !new_sec)
            start_ok = 1'b0;
        if (level_q == flash_prot_pkg::LVL_2 && new_level != flash_prot_pkg::LVL_2)
        begin
            if (!key_cfg_q || !auth_q || new_level != flash_prot_pkg::LVL_1)
                start_ok = 1'b0;
        end
        if (level_q == flash_prot_pkg::LVL_1 && new_level < flash_prot_pkg::LVL_1)
        begin
            if (key_cfg_q && !auth_q)
                start_ok = 1'b0;
        end
    end

    // Option load sequencer: capture after reset and after each accepted program
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ob_state_q <= flash_prot_pkg::OB_SYNC;
            wait_q <= flash_prot_pkg::SYNC_WAIT;
        end
        else
        begin
            case (ob_state_q)
                flash_prot_pkg::OB_SYNC:
                begin
                    if (wait_q == 3'h0)
                        ob_state_q <= flash_prot_pkg::OB_IDLE;
                    else
                        wait_q <= wait_q - 3'h1;
                end
                flash_prot_pkg::OB_IDLE:
                begin
                    if (start_req && start_ok)
                        ob_state_q <= flash_prot_pkg::OB_PROG;
                end
                flash_prot_pkg::OB_PROG:
                begin
                    ob_state_q <= flash_prot_pkg::OB_SYNC;
                    wait_q <= flash_prot_pkg::SYNC_WAIT;
                end
                default:
                    ob_state_q <= flash_prot_pkg::OB_SYNC;
            endcase
        end
    end

    // Active options, held between loads
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            level_q <= flash_prot_pkg::LVL_2; // Most restrictive until loaded
            sec_en_q <= 1'b0;
            key_cfg_q <= 1'b0;
            wrp_q <= '0;
            key_q <= '0;
            boot_q <= flash_prot_pkg::SRC_USER;
        end
        else if (ob_state_q == flash_prot_pkg::OB_SYNC && wait_q == 3'h0)
        begin
            level_q <= flash_prot_pkg::rdp_level_t'(s_level);
            sec_en_q <= s_sec_en;
            key_cfg_q <= s_key_cfg;
            wrp_q <= s_wrp;
            key_q <= s_key;
            boot_q <= s_boot;
        end
    end

    // Program strobe and data toward the option store
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nv_prog <= 1'b0;
            nv_prog_opt <= '0;
            nv_prog_wrp <= '0;
            nv_prog_key <= '0;
        end
        else
        begin
            nv_prog <= start_req && start_ok;
            if (start_req && start_ok)
            begin
                nv_prog_opt <= opt_stage_q;
                nv_prog_wrp <= wrp_stage_q;
                nv_prog_key <= key_stage_q;
            end
        end
    end

    // Erase and clear pulses on accepted regression from level 1
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mass_erase <= 1'b0;
            backup_clear <= 1'b0;
        end
        else
        begin
            mass_erase <= start_req && start_ok && level_q == flash_prot_pkg::LVL_1
                && new_level == flash_prot_pkg::LVL_0;
            backup_clear <= start_req && start_ok && level_q == flash_prot_pkg::LVL_1
                && new_level < flash_prot_pkg::LVL_1;
        end
    end

    // Software staging, prefetch and refusal flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prefetch_q <= 1'b0;
            opt_stage_q <= '0;
            wrp_stage_q <= '0;
            key_stage_q <= '0;
            refused_q <= 1'b0;
        end
        else
        begin
            if (bus_wr && paddr == flash_prot_pkg::CTRL_OFF)
                prefetch_q <= pwdata[flash_prot_pkg::CTRL_PREFETCH_BIT];
            if (bus_wr && paddr == flash_prot_pkg::OPT_STAGE_OFF)
                opt_stage_q <= pwdata[flash_prot_pkg::OPT_W-1:0];
            if (bus_wr && paddr == flash_prot_pkg::WRP_STAGE_OFF)
                wrp_stage_q <= pwdata[4*PAGE_W-1:0];
            if (bus_wr && paddr == flash_prot_pkg::KEY_STAGE_OFF)
                key_stage_q <= pwdata;
            if (start_req)
                refused_q <= !start_ok;
        end
    end

    // Password check; level 2 needs an attached debugger, cleared by each option load
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            auth_q <= 1'b0;
        else if (bus_wr && paddr == flash_prot_pkg::PASSWORD_OFF)
            auth_q <= key_cfg_q && (pwdata == key_q)
                && (level_q != flash_prot_pkg::LVL_2 || s_dbg);
        else if (ob_state_q == flash_prot_pkg::OB_PROG)
            auth_q <= 1'b0;
    end

    // Debug and boot permissions from the active level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dbg_enable <= 1'b0;
            dbg_secure_enable <= 1'b0;
            boot_ram_allow <= 1'b0;
            boot_loader_allow <= 1'b0;
        end
        else
        begin
            dbg_enable <= (level_q != flash_prot_pkg::LVL_2);
            dbg_secure_enable <= (level_q == flash_prot_pkg::LVL_0);
            boot_ram_allow <= (level_q == flash_prot_pkg::LVL_0) || (level_q == flash_prot_pkg::LVL_HALF)
                || (level_q == flash_prot_pkg::LVL_1 && !sec_en_q);
            boot_loader_allow <= (level_q != flash_prot_pkg::LVL_2);
        end
    end

    // Effective source: an attached debugger or a non-user boot taints every access
    flash_prot_pkg::src_t eff_src;
    logic grant_c;
    always_comb
    begin
        if (s_dbg)
            eff_src = flash_prot_pkg::SRC_DEBUG;
        else if (boot_q != flash_prot_pkg::SRC_USER)
            eff_src = flash_prot_pkg::src_t'(boot_q);
        else
            eff_src = flash_prot_pkg::src_t'(acc_src);
    end

    access_policy #(
        .PAGE_W(PAGE_W)
    ) u_policy (
        .level(level_q),
        .sec_en(sec_en_q),
        .src(eff_src),
        .area(flash_prot_pkg::area_t'(acc_area)),
        .op(flash_prot_pkg::op_t'(acc_op)),
        .secure(acc_secure),
        .page(acc_page),
        .write_protect_area(wrp_q),
        .otp_row_used(otp_used_q[acc_row]),
        .grant(grant_c)
    );

    // Registered access answer, refused while options are loading
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_done <= 1'b0;
            acc_grant <= 1'b0;
        end
        else
        begin
            acc_done <= acc_valid;
            acc_grant <= acc_valid && grant_c && (ob_state_q == flash_prot_pkg::OB_IDLE);
        end
    end

    // One write per OTP row
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            otp_used_q <= '0;
        else if (acc_valid && grant_c && ob_state_q == flash_prot_pkg::OB_IDLE
            && acc_area == flash_prot_pkg::AREA_OTP && acc_op == flash_prot_pkg::OP_WRITE)
            otp_used_q[acc_row] <= 1'b1;
    end

    // APB slave: one wait state, read data and error registered with pready
    always_comb
    begin
        mapped = 1'b1;
        if (paddr == flash_prot_pkg::CTRL_OFF || paddr == flash_prot_pkg::OPT_STAGE_OFF)
            mapped = 1'b1;
        else if (paddr == flash_prot_pkg::WRP_STAGE_OFF || paddr == flash_prot_pkg::KEY_STAGE_OFF)
            mapped = 1'b1;
        else if (paddr == flash_prot_pkg::PASSWORD_OFF || paddr == flash_prot_pkg::STATUS_OFF)
            mapped = 1'b1;
        else if (paddr == flash_prot_pkg::OTP_USED_OFF)
            mapped = 1'b1;
        else
            mapped = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= bus_rd_phase;
            pslverr_q <= bus_rd_phase && !mapped;
            prdata_q <= '0;
            if (bus_rd_phase && !pwrite)
            begin
                if (paddr == flash_prot_pkg::CTRL_OFF)
                    prdata_q[flash_prot_pkg::CTRL_PREFETCH_BIT] <= prefetch_q;
                else if (paddr == flash_prot_pkg::OPT_STAGE_OFF)
                    prdata_q[flash_prot_pkg::OPT_W-1:0] <= opt_stage_q;
                else if (paddr == flash_prot_pkg::WRP_STAGE_OFF)
                    prdata_q[4*PAGE_W-1:0] <= wrp_stage_q;
                else if (paddr == flash_prot_pkg::STATUS_OFF)
                begin
                    prdata_q[flash_prot_pkg::ST_LVL_LSB +: 2] <= level_q;
                    prdata_q[flash_prot_pkg::ST_SEC_BIT] <= sec_en_q;
                    prdata_q[flash_prot_pkg::ST_KEYCFG_BIT] <= key_cfg_q;
                    prdata_q[flash_prot_pkg::ST_AUTH_BIT] <= auth_q;
                    prdata_q[flash_prot_pkg::ST_BUSY_BIT] <= (ob_state_q != flash_prot_pkg::OB_IDLE);
                    prdata_q[flash_prot_pkg::ST_REFUSED_BIT] <= refused_q;
                    prdata_q[flash_prot_pkg::ST_DBG_BIT] <= dbg_enable;
                    prdata_q[flash_prot_pkg::ST_PREFETCH_BIT] <= prefetch_q;
                end
                else if (paddr == flash_prot_pkg::OTP_USED_OFF)
                    prdata_q[OTP_ROWS-1:0] <= otp_used_q;
            end
        end
    end

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign prefetch_en = prefetch_q;
endmodule : flash_prot

// File: testbench/nv_store.sv
// Option store model: latches staged options on each program pulse.
// Assumes the block holds nv_prog_* steady while nv_prog is high.
`timescale 1ns/1ps
module nv_store (
    input wire logic pclk,
    input wire logic nv_prog,
    input wire logic [3:0] nv_prog_opt,
    input wire logic [27:0] nv_prog_wrp,
    input wire logic [31:0] nv_prog_key,
    output logic [1:0] nv_level,
    output logic nv_sec_en,
    output logic nv_key_cfg,
    output logic [27:0] nv_wrp,
    output logic [31:0] nv_key
);
    // Blank part: level 0, security on, no key, both areas empty
    initial {nv_key_cfg, nv_sec_en, nv_level, nv_wrp, nv_key} = {4'h4, 28'h0004001, 32'h0};
    // Contents change only on a program pulse
    always @(posedge pclk)
        if (nv_prog)
            {nv_key_cfg, nv_sec_en, nv_level, nv_wrp, nv_key} <= {nv_prog_opt, nv_prog_wrp, nv_prog_key};
endmodule : nv_store

// File: testbench/flash_prot_sva.sv
// Checker for the flash protection block, on its top ports.
// Assumes one clock pclk and async active-low presetn.
`timescale 1ns/1ps
module flash_prot_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic acc_valid,
    input wire logic acc_done,
    input wire logic acc_grant,
    input wire logic nv_prog,
    input wire logic prefetch_en,
    input wire logic mass_erase,
    input wire logic backup_clear
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Control write completing at this edge
    logic ctrl_wr;
    assign ctrl_wr = psel && penable && pready && pwrite && paddr == 8'h00;
    a_apb_one_wait: assert property (psel && !penable |-> ##2 pready) else $error("ready late");
    a_query_answer: assert property (acc_valid |=> acc_done) else $error("no done");
    a_grant_cause: assert property (acc_grant |-> acc_done && $past(acc_valid)) else $error("stray grant");
    a_load_blocks: assert property ($rose(presetn) |-> !acc_grant [*5]) else $error("early grant");
    a_prog_cause: assert property (nv_prog |-> $past(ctrl_wr && pwdata[1])) else $error("stray prog");
    a_erase_pair: assert property (mass_erase |-> nv_prog && backup_clear) else $error("lone erase");
    a_clear_prog: assert property (backup_clear |-> nv_prog) else $error("stray clear");
    a_prefetch_set: assert property ($rose(prefetch_en) |-> $past(ctrl_wr && pwdata[0])) else $error("prefetch");
endmodule : flash_prot_sva
bind flash_prot flash_prot_sva flash_prot_sva_i (.*);

// File: testbench/tb.sv
// Bench for the flash protection block with option store model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, acc_valid = 1'b0;
    logic acc_secure = 1'b0, pready, pslverr, nv_sec_en, nv_key_cfg, nv_prog, acc_done, acc_grant, err;
    logic dbg_enable, dbg_secure_enable, boot_ram_allow, boot_loader_allow, prefetch_en, mass_erase, backup_clear;
    logic [1:0] nv_level, acc_src = 2'h0, acc_op = 2'h0;
    logic [2:0] acc_area = 3'h0;
    logic [3:0] nv_prog_opt;
    logic [4:0] acc_row = 5'h00;
    logic [6:0] acc_page = 7'h00;
    logic [7:0] paddr = 8'h00;
    logic [27:0] nv_wrp, nv_prog_wrp;
    logic [31:0] pwdata = 32'h0, prdata, nv_key, nv_prog_key, rd;
    int fails = 0, n_tests = 0;
    logic dbg_attached = 1'b0;
    flash_prot flash_prot_i (.boot_sel(2'h0), .*);
    nv_store nv_store_i (.*);
    initial forever #20 pclk = ~pclk;
    task finish_test;
        if (fails == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; waits for pready, then one idle cycle
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
        chk(k < 20, 1'b1);
        if (k >= 20) finish_test;
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // Status polled until the option load is over
    task settle;
        for (int k = 0; k < 20; k++)
        begin
            apb(1'b0, 8'h14, 32'h0);
            if (rd[5] === 1'b0) return;
        end
        chk(1'b0, 1'b1);
        finish_test;
    endtask : settle
    // Stage options, then start programming
    task prog(input logic [3:0] o);
        apb(1'b1, 8'h04, {28'h0, o});
        apb(1'b1, 8'h00, 32'h2);
    endtask : prog
    // One access query; page also feeds the OTP row
    task acc(input logic [1:0] s, input logic [2:0] ar, input logic [1:0] o, input logic sc, input logic [6:0] pg,
        input logic exp);
        acc_valid <= 1'b1; acc_src <= s; acc_area <= ar; acc_op <= o;
        acc_secure <= sc; acc_page <= pg; acc_row <= pg[4:0];
        @(posedge pclk) acc_valid <= 1'b0;
        @(posedge pclk);
        chk(acc_done, 1'b1);
        chk(acc_grant, exp);
    endtask : acc
    task t_level0;
        chk(rd[1:0], 2'h0);
        chk(prefetch_en, 1'b0);
        apb(1'b1, 8'h00, 32'h1);
        chk(prefetch_en, 1'b1);
        acc(2'h1, 3'h0, 2'h0, 1'b1, 7'h00, 1'b1);
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1'b1);
    endtask : t_level0
    task t_half;
        apb(1'b1, 8'h08, 32'h0004182);
        prog(4'h5);
        settle;
        chk(rd[2:0], 3'h5);
        acc(2'h0, 3'h0, 2'h1, 1'b0, 7'h02, 1'b0);
        acc(2'h0, 3'h0, 2'h2, 1'b0, 7'h03, 1'b0);
        acc(2'h1, 3'h0, 2'h1, 1'b0, 7'h04, 1'b1);
        acc(2'h1, 3'h0, 2'h0, 1'b1, 7'h04, 1'b0);
    endtask : t_half
    task t_level1;
        prog(4'h2);
        dbg_attached <= 1'b1;
        settle;
        acc(2'h0, 3'h0, 2'h0, 1'b0, 7'h04, 1'b0);
        dbg_attached <= 1'b0;
        acc(2'h2, 3'h0, 2'h0, 1'b0, 7'h04, 1'b0);
        acc(2'h0, 3'h0, 2'h2, 1'b0, 7'h04, 1'b1);
        acc(2'h0, 3'h1, 2'h1, 1'b0, 7'h00, 1'b0);
        acc(2'h3, 3'h1, 2'h0, 1'b0, 7'h00, 1'b1);
        acc(2'h1, 3'h4, 2'h1, 1'b0, 7'h00, 1'b0);
        acc(2'h2, 3'h2, 2'h1, 1'b0, 7'h00, 1'b1);
        acc(2'h1, 3'h3, 2'h1, 1'b0, 7'h01, 1'b1);
        acc(2'h1, 3'h3, 2'h1, 1'b0, 7'h01, 1'b0);
    endtask : t_level1
    task t_down;
        prog(4'h0);
        chk(mass_erase, 1'b1);
        chk(backup_clear, 1'b1);
        settle;
        chk(rd[1:0], 2'h0);
        prog(4'h3);
        settle;
        chk({dbg_enable, dbg_secure_enable, boot_ram_allow, boot_loader_allow}, 4'h0);
        acc(2'h0, 3'h2, 2'h1, 1'b0, 7'h00, 1'b0);
        prog(4'h0);
        settle;
        chk(rd[6:0], 7'h43);
    endtask : t_down
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        settle;
        t_level0;
        t_half;
        t_level1;
        t_down;
        finish_test;
    end
endmodule : tb
